// *** logic/fdl_drive_logic.sv ***
// Purpose: drive-side control logic of a flexible disk drive
// Assumes: all pins synchronous to clk_sys, host pins active low except direction_in and side_select
// Notes:   registers over Avalon-MM, one wait cycle per access
//
// Summary of operation
// - head at track 00 energizes phase 4; inward steps cycle 4,1,2,3,4
// - each accepted step moves the stepper one phase, the head one track
// - track-zero output low while selected and head sits over the outermost track
// - at track zero, outward step commands are ignored
// - spindle runs on request; drive cut after 150 ms without tach pulse
// - erase current on 430 us after write gate goes active
// - erase current off 850 us after write gate goes inactive
// - each write data pulse while write gate is active reverses the write current direction
// - spurious crossover pulses are discarded before shaping
// - each genuine flux transition while write gate is inactive starts a 1 us read data pulse, or restarts one still running
// - index or sector hole drives the revolution output low while selected
// - side choice connects read and write circuits to one head only
// - head solenoid follows unit select or spindle request per strap
// - side choice high selects head zero, low selects head one
// - head motion starts on the trailing edge of the step pulse
// - step commands ignored while write gate is active
// - step commands ignored while the drive is not selected
//
// Added by the designer: the Avalon-MM interface to the registers and the register offsets.
`timescale 1ns/1ps
module fdl_drive_logic #(
  parameter int STALL_CYC     = fdl_pkg::STALL_CYCLES,
  parameter int ERASE_ON_CYC  = fdl_pkg::ERASE_ON_CYCLES,
  parameter int ERASE_OFF_CYC = fdl_pkg::ERASE_OFF_CYCLES,
  parameter int XOVER_MIN     = fdl_pkg::XOVER_MIN_CYCLES
) (
  input  wire logic        clk_sys,
  input  wire logic        rst_n,
  // avalon-mm slave
  input  wire logic [3:0]  avs_address,
  input  wire logic        avs_read,
  input  wire logic        avs_write,
  input  wire logic [31:0] avs_writedata,
  output logic [31:0]      avs_readdata,
  output logic             avs_waitrequest,
  // host interface
  input  wire logic        drive_select_n,
  input  wire logic        motor_on_n,
  input  wire logic        step_n,
  input  wire logic        direction_in,
  input  wire logic        write_gate_n,
  input  wire logic        write_data_n,
  input  wire logic        side_select,
  output logic             track_zero_n,
  output logic             index_n,
  output logic             read_data_n,
  // drive mechanics and sensors
  input  wire logic        track0_sensor,
  input  wire logic        index_sensor,
  input  wire logic        tach_pulse,
  input  wire logic        xover_pulse,
  output logic [3:0]       phase_on,
  output logic             motor_drive,
  output logic             head_load,
  output logic             erase_on,
  output logic             write_dir,
  output logic             head0_en,
  output logic             head1_en
);
  localparam int STALL_W = $clog2(STALL_CYC + 1);
  localparam int ERASE_W = $clog2(ERASE_OFF_CYC + ERASE_ON_CYC + 1);
  localparam int RP_W    = $clog2(fdl_pkg::READ_PULSE_CYCLES + 1);
  localparam int XF_W    = $clog2(XOVER_MIN + 1);

  // ------------------------------------------------------------
  // host pin decode
  // ------------------------------------------------------------
  wire selected   = !drive_select_n;
  wire motor_req  = !motor_on_n;
  wire gate_on    = !write_gate_n;
  logic step_n_reg;
  logic wdata_n_reg;
  logic xover_reg;
  // trailing edge of the low step pulse
  wire step_edge  = !step_n_reg && step_n;
  wire wdata_edge = wdata_n_reg && !write_data_n;

  // ------------------------------------------------------------
  // stepper
  // ------------------------------------------------------------
  logic [1:0] pos_reg;
  logic [1:0] pos_next;
  logic [7:0] track_reg;
  logic [7:0] track_next;
  logic [3:0] phase_next;
  // sensor may also see light at tracks 01 and 02, so qualify by phase 4
  wire at_track0 = track0_sensor && (pos_reg == fdl_pkg::POS_RST);
  wire out_block = at_track0 && !direction_in;
  wire step_ok   = step_edge && selected && !gate_on && !out_block;

  always_comb begin
    pos_next   = pos_reg;
    track_next = track_reg;
    if (step_ok) begin
      if (direction_in) begin
        pos_next   = pos_reg + 2'h1;
        track_next = track_reg + 8'h01;
      end else begin
        pos_next   = pos_reg - 2'h1;
        track_next = (track_reg == 8'h00) ? 8'h00 : track_reg - 8'h01;
      end
    end
  end

  // position 0 = phase 4, 1 = phase 1, 2 = phase 2, 3 = phase 3
  always_comb begin
    unique case (pos_next)
      2'h0: phase_next = 4'h8;
      2'h1: phase_next = 4'h1;
      2'h2: phase_next = 4'h2;
      2'h3: phase_next = 4'h4;
    endcase
  end

  // ------------------------------------------------------------
  // spindle stall watch
  // ------------------------------------------------------------
  logic [STALL_W-1:0] stall_cnt_reg;
  logic               stalled_reg;
  wire stall_hit = stall_cnt_reg == STALL_W'(STALL_CYC - 1);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      stall_cnt_reg <= '0;
      stalled_reg   <= 1'b0;
    end else if (!motor_req) begin
      // dropping the request re-arms the start trigger
      stall_cnt_reg <= '0;
      stalled_reg   <= 1'b0;
    end else if (tach_pulse) begin
      stall_cnt_reg <= '0;
    end else if (!stalled_reg) begin
      stall_cnt_reg <= stall_cnt_reg + STALL_W'(1);
      if (stall_hit) begin
        stalled_reg <= 1'b1;
      end
    end
  end

  // ------------------------------------------------------------
  // erase timing
  // ------------------------------------------------------------
  logic [ERASE_W-1:0] erase_cnt_reg;
  wire erase_want   = gate_on != erase_on;
  wire erase_on_hit = erase_cnt_reg == ERASE_W'(ERASE_ON_CYC - 1);
  wire erase_off_hit = erase_cnt_reg == ERASE_W'(ERASE_OFF_CYC - 1);
  wire erase_flip   = erase_want && (gate_on ? erase_on_hit : erase_off_hit);

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      erase_cnt_reg <= '0;
      erase_on      <= 1'b0;
    end else if (!erase_want || erase_flip) begin
      // a gate change mid-delay cancels the pending change and clears the count
      erase_cnt_reg <= '0;
      if (erase_flip) begin
        erase_on <= gate_on;
      end
    end else begin
      erase_cnt_reg <= erase_cnt_reg + ERASE_W'(1);
    end
  end

  // ------------------------------------------------------------
  // read path: crossover filter and pulse shaper
  // ------------------------------------------------------------
  logic [XF_W-1:0] xf_cnt_reg;
  logic            xf_done_reg;
  logic [RP_W-1:0] rp_cnt_reg;
  // a crossover counts only after holding for XOVER_MIN cycles
  wire xf_hit  = xover_reg && (xf_cnt_reg == XF_W'(XOVER_MIN - 1));
  wire flux_ok = xf_hit && !xf_done_reg && !gate_on;

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      xf_cnt_reg  <= '0;
      xf_done_reg <= 1'b0;
    end else if (!xover_reg) begin
      xf_cnt_reg  <= '0;
      xf_done_reg <= 1'b0;
    end else if (xf_hit) begin
      xf_done_reg <= 1'b1;
    end else begin
      xf_cnt_reg <= xf_cnt_reg + XF_W'(1);
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      rp_cnt_reg  <= '0;
      read_data_n <= 1'b1;
    end else if (flux_ok) begin
      // a new transition restarts the pulse count, so close transitions merge into one longer pulse
      rp_cnt_reg  <= RP_W'(fdl_pkg::READ_PULSE_CYCLES - 1);
      read_data_n <= 1'b0;
    end else if (rp_cnt_reg != '0) begin
      rp_cnt_reg <= rp_cnt_reg - RP_W'(1);
    end else begin
      read_data_n <= 1'b1;
    end
  end

  // ------------------------------------------------------------
  // register file
  // ------------------------------------------------------------
  logic        load_motor_reg;
  logic [31:0] rd_mux;
  wire acc_start = (avs_read || avs_write) && avs_waitrequest;
  wire wr_take   = avs_write && !avs_waitrequest;
  wire ctrl_hit  = avs_address == fdl_pkg::CTRL_ADDR;

  always_comb begin
    rd_mux = 32'h0000_0000;
    unique case (avs_address)
      fdl_pkg::CTRL_ADDR:
        rd_mux[fdl_pkg::CTRL_LOAD_MOTOR_BIT] = load_motor_reg;
      fdl_pkg::STATUS_ADDR: begin
        rd_mux[fdl_pkg::ST_PHASE_LSB +: 4]  = phase_on;
        rd_mux[fdl_pkg::ST_TRACK0_BIT]      = at_track0;
        rd_mux[fdl_pkg::ST_MOTOR_BIT]       = motor_drive;
        rd_mux[fdl_pkg::ST_STALL_BIT]       = stalled_reg;
        rd_mux[fdl_pkg::ST_ERASE_BIT]       = erase_on;
        rd_mux[fdl_pkg::ST_HEAD1_BIT]       = head1_en;
        rd_mux[fdl_pkg::ST_WDIR_BIT]        = write_dir;
        rd_mux[fdl_pkg::ST_LOAD_BIT]        = head_load;
      end
      fdl_pkg::TRACK_ADDR: rd_mux[7:0] = track_reg;
      fdl_pkg::ID_ADDR:    rd_mux = fdl_pkg::ID_VALUE;
      default:             rd_mux = 32'h0000_0000;
    endcase
  end

  // one wait cycle, then a single low cycle per access
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_waitrequest <= 1'b1;
    end else begin
      avs_waitrequest <= !acc_start;
    end
  end

  // read data is loaded with the answer and held until the next read
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      avs_readdata <= 32'h0000_0000;
    end else if (acc_start && avs_read) begin
      avs_readdata <= rd_mux;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      load_motor_reg <= fdl_pkg::CTRL_LOAD_MOTOR_RST;
    end else if (wr_take && ctrl_hit) begin
      load_motor_reg <= avs_writedata[fdl_pkg::CTRL_LOAD_MOTOR_BIT];
    end
  end

  // ------------------------------------------------------------
  // input sampling
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      step_n_reg  <= 1'b1;
      wdata_n_reg <= 1'b1;
      xover_reg   <= 1'b0;
    end else begin
      step_n_reg  <= step_n;
      wdata_n_reg <= write_data_n;
      xover_reg   <= xover_pulse;
    end
  end

  // ------------------------------------------------------------
  // stepper state
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      pos_reg   <= fdl_pkg::POS_RST;
      track_reg <= fdl_pkg::TRACK_RST;
      phase_on  <= fdl_pkg::PHASE_RST;
    end else begin
      pos_reg   <= pos_next;
      track_reg <= track_next;
      phase_on  <= phase_next;
    end
  end

  // ------------------------------------------------------------
  // host status outputs
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      track_zero_n <= 1'b1;
      index_n      <= 1'b1;
    end else begin
      // track zero and index outputs only answer while the drive is selected
      track_zero_n <= !(at_track0 && selected);
      index_n      <= !(index_sensor && selected);
    end
  end

  // ------------------------------------------------------------
  // spindle drive and head load
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      motor_drive <= 1'b0;
      head_load   <= 1'b0;
    end else begin
      motor_drive <= motor_req && !stalled_reg;
      // strap: 1 loads the head with the spindle request
      head_load   <= load_motor_reg ? motor_req : selected;
    end
  end

  // ------------------------------------------------------------
  // write current and head choice
  // ------------------------------------------------------------
  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      write_dir <= 1'b0;
    end else if (gate_on && wdata_edge) begin
      // each reversal of the write current records one bit
      write_dir <= !write_dir;
    end
  end

  always_ff @(posedge clk_sys or negedge rst_n) begin
    if (!rst_n) begin
      head0_en <= 1'b1;
      head1_en <= 1'b0;
    end else begin
      head0_en <= side_select;
      head1_en <= !side_select;
    end
  end

endmodule

// *** logic/fdl_pkg.sv ***
// Purpose: shared constants of the disk drive control logic
// Assumes: 25 MHz system clock
// Notes:   times kept in their own unit, cycles derived here
package fdl_pkg;
  // ------------------------------------------------------------
  // clock and timing
  // ------------------------------------------------------------
  localparam int CLK_HZ          = 25000000;
  localparam int CYC_PER_US      = CLK_HZ / 1000000;
  localparam int STALL_MS        = 150;
  localparam int ERASE_ON_US     = 430;
  localparam int ERASE_OFF_US    = 850;
  localparam int READ_PULSE_US   = 1;
  localparam int STALL_CYCLES    = STALL_MS * 1000 * CYC_PER_US;
  localparam int ERASE_ON_CYCLES = ERASE_ON_US * CYC_PER_US;
  localparam int ERASE_OFF_CYCLES = ERASE_OFF_US * CYC_PER_US;
  localparam int READ_PULSE_CYCLES = READ_PULSE_US * CYC_PER_US;
  localparam int XOVER_MIN_CYCLES = 2;
  // ------------------------------------------------------------
  // register map (byte addresses, 32-bit words)
  // ------------------------------------------------------------
  localparam logic [3:0] CTRL_ADDR   = 4'h0;
  localparam logic [3:0] STATUS_ADDR = 4'h4;
  localparam logic [3:0] TRACK_ADDR  = 4'h8;
  localparam logic [3:0] ID_ADDR     = 4'hc;
  // ctrl fields
  localparam int CTRL_LOAD_MOTOR_BIT = 0;
  localparam logic CTRL_LOAD_MOTOR_RST = 1'b0;
  // status fields
  localparam int ST_PHASE_LSB   = 0;
  localparam int ST_TRACK0_BIT  = 4;
  localparam int ST_MOTOR_BIT   = 5;
  localparam int ST_STALL_BIT   = 6;
  localparam int ST_ERASE_BIT   = 7;
  localparam int ST_HEAD1_BIT   = 8;
  localparam int ST_WDIR_BIT    = 9;
  localparam int ST_LOAD_BIT    = 10;
  // stepper position 0 energizes phase 4 (outermost track)
  localparam logic [1:0] POS_RST = 2'h0;
  localparam logic [3:0] PHASE_RST = 4'h8;
  localparam logic [7:0] TRACK_RST = 8'h00;
  // arbitrary identification value
  localparam logic [31:0] ID_VALUE = 32'h0000_5a01;
endpackage

// *** testbench/fdl_drive_logic_chk.sv ***
// Purpose: concurrent checks on the drive logic ports
// Assumes: shortened erase counts handed on by the bind
// Notes:   one clock domain, reset disables every check
`timescale 1ns/1ps
module fdl_drive_logic_chk #(
  parameter int ERASE_ON_CYC  = 20,
  parameter int ERASE_OFF_CYC = 40
) (
  input wire logic       clk_sys,
  input wire logic       rst_n,
  input wire logic [3:0] phase_on,
  input wire logic       track_zero_n,
  input wire logic       write_gate_n,
  input wire logic       drive_select_n,
  input wire logic       side_select,
  input wire logic       head0_en,
  input wire logic       head1_en,
  input wire logic       erase_on,
  input wire logic       write_dir,
  input wire logic       read_data_n,
  input wire logic       index_n,
  input wire logic       index_sensor,
  input wire logic       motor_drive,
  input wire logic       motor_on_n,
  input wire logic       step_n
);
  localparam int OFF_LO = ERASE_OFF_CYC - 10;
  localparam int OFF_HI = ERASE_OFF_CYC - 4;
  int gcnt;
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!rst_n);
  // a gated step drops the gate briefly, so erase-on is judged by run length
  always_ff @(posedge clk_sys or negedge rst_n)
    if (!rst_n) gcnt <= 0;
    else gcnt <= write_gate_n ? 0 : gcnt + 1;
  chk_phase_hot: assert property ($onehot(phase_on))
    else $error("phase not one-hot");
  chk_step_gate: assert property ($changed(phase_on) |->
    $past(write_gate_n) && !$past(drive_select_n))
    else $error("step taken while gated");
  chk_step_trail: assert property ($changed(phase_on) |->
    $past(step_n) && !$past(step_n, 2))
    else $error("step not taken on trailing edge");
  chk_t0_phase: assert property (!track_zero_n |->
    phase_on == 4'h8 || $past(phase_on) == 4'h8)
    else $error("track zero off phase four");
  chk_head_excl: assert property (head0_en != head1_en)
    else $error("head enables clash");
  chk_side_map: assert property (head0_en == $past(side_select))
    else $error("head choice wrong");
  chk_erase_rise: assert property ($rose(erase_on) |->
    gcnt >= ERASE_ON_CYC - 1 && gcnt <= ERASE_ON_CYC + 2)
    else $error("erase on at wrong time");
  chk_erase_fall: assert property ($rose(write_gate_n) && erase_on |->
    erase_on[*8] ##[OFF_LO:OFF_HI] !erase_on)
    else $error("erase off at wrong time");
  chk_wdir_gate: assert property ($changed(write_dir) |-> !$past(write_gate_n))
    else $error("write current flipped ungated");
  chk_read_width: assert property ($fell(read_data_n) |->
    ##24 !read_data_n ##1 read_data_n)
    else $error("read pulse width wrong");
  chk_index_map: assert property (index_n ==
    !($past(index_sensor) && !$past(drive_select_n)))
    else $error("index output wrong");
  chk_motor_req: assert property (motor_drive |-> !$past(motor_on_n))
    else $error("motor driven unrequested");
  cov_erase: cover property ($rose(erase_on));
  cov_read: cover property ($fell(read_data_n));
  cov_step: cover property ($changed(phase_on));
  cov_stall: cover property ($fell(motor_drive));
endmodule
bind fdl_drive_logic fdl_drive_logic_chk #(
  .ERASE_ON_CYC(ERASE_ON_CYC), .ERASE_OFF_CYC(ERASE_OFF_CYC)) u_chk (.*);

// *** testbench/fdl_drive_logic_tb.sv ***
// Purpose: self-checking bench for the drive logic
// Assumes: shortened stall and erase counts
// Notes:   step and write pins come from the host model, the other host pins from the bench
`timescale 1ns/1ps
module fdl_drive_logic_tb;
  logic        clk_sys, rst_n, avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address, phase_on;
  logic [31:0] avs_writedata, avs_readdata, rd;
  logic        drive_select_n, motor_on_n, step_n, direction_in, write_gate_n;
  logic        write_data_n, side_select, track_zero_n, index_n, read_data_n;
  logic        track0_sensor, index_sensor, tach_pulse, xover_pulse, motor_drive;
  logic        head_load, erase_on, write_dir, head0_en, head1_en;
  int          err_total, samples_checked, trk, n;
  fdl_drive_logic #(.STALL_CYC(200), .ERASE_ON_CYC(20), .ERASE_OFF_CYC(40),
    .XOVER_MIN(2)) dut (.*);
  fdl_host_model h (.*);
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic bus(input logic wr, input logic [3:0] a, input logic [31:0] d);
    avs_address <= a;
    avs_write <= wr;
    avs_read <= !wr;
    avs_writedata <= d;
    @(posedge clk_sys);
    while (avs_waitrequest !== 1'b0) begin
      @(posedge clk_sys);
    end
    rd = avs_readdata;
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_sys);
  endtask
  task automatic stp(input logic dir, input logic gate, input int dt);
    h.step_once(dir, gate);
    trk += dt;
    track0_sensor <= (trk == 0);
    repeat (2) @(posedge clk_sys);
  endtask
  task automatic t_regs();
    chk("t0_rst", track_zero_n, 0);
    bus(0, 4'h4, 0);
    chk("status", rd, 32'h0000_0418);
    bus(0, 4'h2, 0);
    chk("unmapped", rd, 0);
    bus(1, 4'h0, 1);
    bus(0, 4'h0, 0);
    chk("ctrl", rd, 1);
    chk("load_off", head_load, 0);
    $display("t_regs done");
  endtask
  task automatic t_step();
    for (int i = 0; i < 4; i++) begin
      stp(1, 0, 1);
      chk("phase_in", phase_on, 4'h1 << ((trk + 3) % 4));
    end
    bus(0, 4'h8, 0);
    chk("track", rd[7:0], 4);
    for (int i = 0; i < 4; i++) begin
      stp(0, 0, -1);
      chk("phase_out", phase_on, 4'h1 << ((trk + 3) % 4));
    end
    chk("t0_out", track_zero_n, 0);
    stp(0, 0, 0);
    chk("t0_stop", phase_on, 4'h8);
    drive_select_n <= 1'b1;
    stp(1, 0, 0);
    chk("desel", phase_on, 4'h8);
    drive_select_n <= 1'b0;
    stp(1, 1, 0);
    chk("gated", phase_on, 4'h8);
    $display("t_step done");
  endtask
  task automatic t_write();
    side_select <= 1'b0;
    fork
      h.write_burst(3);
      begin
        // erase current must be on well inside the write window
        repeat (180) @(posedge clk_sys);
        chk("erase_mid", erase_on, 1);
      end
    join
    chk("wdir", write_dir, 1);
    chk("head1", head1_en, 1);
    chk("head0", head0_en, 0);
    chk("erase", erase_on, 0);
    side_select <= 1'b1;
    $display("t_write done");
  endtask
  task automatic t_read();
    xover_pulse <= 1'b1;
    @(posedge clk_sys);
    xover_pulse <= 1'b0;
    repeat (10) @(posedge clk_sys);
    chk("short", read_data_n, 1);
    xover_pulse <= 1'b1;
    repeat (2) @(posedge clk_sys);
    xover_pulse <= 1'b0;
    n = 0;
    repeat (40) begin
      @(posedge clk_sys);
      n += (read_data_n === 1'b0);
    end
    chk("rd_width", n, 25);
    $display("t_read done");
  endtask
  task automatic t_motor();
    motor_on_n <= 1'b0;
    repeat (150) begin
      tach_pulse <= ~tach_pulse;
      @(posedge clk_sys);
    end
    chk("run", motor_drive, 1);
    chk("load_m", head_load, 1);
    tach_pulse <= 1'b0;
    repeat (190) @(posedge clk_sys);
    chk("hold", motor_drive, 1);
    repeat (20) @(posedge clk_sys);
    chk("stall", motor_drive, 0);
    motor_on_n <= 1'b1;
    bus(1, 4'h0, 0);
    repeat (3) @(posedge clk_sys);
    chk("load_s", head_load, 1);
    drive_select_n <= 1'b1;
    index_sensor <= 1'b1;
    repeat (3) @(posedge clk_sys);
    chk("load_d", head_load, 0);
    chk("idx_d", index_n, 1);
    drive_select_n <= 1'b0;
    repeat (3) @(posedge clk_sys);
    chk("idx", index_n, 0);
    index_sensor <= 1'b0;
    $display("t_motor done");
  endtask
  task automatic report_and_stop();
    $display("checks %0d mismatches %0d", samples_checked, err_total);
    if (err_total == 0 && samples_checked > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask
  initial begin
    clk_sys = 1'b0;
    forever #20 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (60000) @(posedge clk_sys);
    err_total++;
    report_and_stop();
  end
  initial begin
    {rst_n, avs_read, avs_write, avs_address, avs_writedata} = '0;
    {drive_select_n, motor_on_n, side_select, track0_sensor} = 4'hf;
    {index_sensor, tach_pulse, xover_pulse, drive_select_n} = 4'h0;
    trk = 0;
    repeat (5) @(posedge clk_sys);
    rst_n <= 1'b1;
    repeat (2) @(posedge clk_sys);
    t_regs();
    t_step();
    t_write();
    t_read();
    t_motor();
    report_and_stop();
  end
endmodule

// *** testbench/fdl_host_model.sv ***
// Purpose: host controller model driving step and write pins
// Assumes: pins change just after a rising edge
// Notes:   long host waits shortened by parameter
`timescale 1ns/1ps
module fdl_host_model #(
  parameter int SETTLE_CYC = 50,
  parameter int LEAD_CYC   = 100,
  parameter int TURN_CYC   = 25000
) (
  input  wire logic clk_sys,
  output logic      step_n,
  output logic      direction_in,
  output logic      write_gate_n,
  output logic      write_data_n
);
  initial begin
    step_n = 1'b1;
    direction_in = 1'b1;
    write_gate_n = 1'b1;
    write_data_n = 1'b1;
  end
  task automatic step_once(input logic dir, input logic gate);
    direction_in <= dir;
    write_gate_n <= !gate;
    @(posedge clk_sys);
    step_n <= 1'b0;
    repeat (2) @(posedge clk_sys);
    step_n <= 1'b1;
    repeat (4) @(posedge clk_sys);
    write_gate_n <= 1'b1;
  endtask
  task automatic write_burst(input int n);
    // spin-up, engage and settle waits overlap in one span
    repeat (SETTLE_CYC) @(posedge clk_sys);
    write_gate_n <= 1'b0;
    repeat (LEAD_CYC) @(posedge clk_sys);
    for (int i = 0; i < n; i++) begin
      write_data_n <= 1'b0;
      repeat (5) @(posedge clk_sys);
      write_data_n <= 1'b1;
      repeat (20) @(posedge clk_sys);
    end
    repeat (LEAD_CYC) @(posedge clk_sys);
    write_gate_n <= 1'b1;
    repeat (TURN_CYC) @(posedge clk_sys);
  endtask
endmodule
